// File: hw/rdct_evsync.sv
// Event pin synchroniser with rising-edge detector
module rdct_evsync (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic pin_in,
	output logic event_out
);
	import rdct_pkg::*;

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// First stage feeds only the second stage
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			prev_q <= 1'b0;
			event_out <= 1'b0;
		end else begin
			prev_q <= sync_q;
			event_out <= sync_q & ~prev_q;
		end
	end

endmodule

// File: hw/rdct_top.sv
// Bank of reloadable sixteen-bit down-counting timers
`include "rdct_params.svh"

module rdct_top #(
	parameter int NUM_CH = `RDCT_NUM_CH,
	parameter int EXT_CH = `RDCT_EXT_CH,
	parameter int OUT_CH = `RDCT_OUT_CH,
	parameter int COUNT_W = `RDCT_CNT_W
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire rdct_pkg::rdct_cfg_s [NUM_CH-1:0] cfg_in,
	input wire logic [NUM_CH-1:0] start_in,
	input wire logic [NUM_CH-1:0] clear_in,
	input wire logic [EXT_CH-1:0] ev_pin_in,
	output rdct_pkg::rdct_stat_s [NUM_CH-1:0] stat_out,
	output logic [OUT_CH-1:0] tout_pin_out,
	output logic [OUT_CH-1:0] tout_pin_oe_n_out
);
	import rdct_pkg::*;

	// Refuse shapes the packed types and the channel split cannot serve
	generate
		if (COUNT_W != `RDCT_CNT_W) begin : g_bad_width
			$error("COUNT_W must match the packed status width");
		end
		if (NUM_CH < 1) begin : g_bad_num
			$error("NUM_CH must be at least one");
		end
		if (EXT_CH + OUT_CH > NUM_CH) begin : g_bad_split
			$error("EXT_CH plus OUT_CH exceeds NUM_CH");
		end
	endgenerate

	// External events, already synchronised and edge detected
	logic [NUM_CH-1:0] ext_event;

	genvar e;
	generate
		for (e = 0; e < NUM_CH; e++) begin : g_ext
			if (e < EXT_CH) begin : g_pin
				rdct_evsync u_sync (
					.mclk_in(mclk_in),
					.nrst_in(nrst_in),
					.pin_in(ev_pin_in[e]),
					.event_out(ext_event[e])
				);
			end else begin : g_none
				// No pin reaches these channels
				assign ext_event[e] = 1'b0;
			end
		end
	endgenerate

	// Per-channel state, nothing shared between channels
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_ch
			rdct_state_e state_q;
			logic [`RDCT_PRE_W-1:0] pre_q;
			logic [`RDCT_CNT_W-1:0] count_q;
			logic tc_flag_q;
			logic tc_pulse_q;
			logic tout_q;
			logic [`RDCT_PRE_W-1:0] tap_mask;
			logic pre_tick;
			logic use_ext;
			logic tick;
			logic at_end;
			logic terminal;
			logic active;

			assign active = (state_q == RDCT_RUN) && cfg_in[c].enable;

			// Tap select
			always_comb begin
				case (cfg_in[c].tap)
					`RDCT_TAP_DIV4: tap_mask = `RDCT_MASK_DIV4;
					`RDCT_TAP_DIV16: tap_mask = `RDCT_MASK_DIV16;
					`RDCT_TAP_DIV64: tap_mask = `RDCT_MASK_DIV64;
					`RDCT_TAP_DIV256: tap_mask = `RDCT_MASK_DIV256;
					default: tap_mask = `RDCT_MASK_DIV256;
				endcase
			end

			// Tick when the selected low bits are all ones
			assign pre_tick = active &&
				((pre_q & tap_mask) == tap_mask);

			// Only the low channels may take the pin as source
			assign use_ext = (c < EXT_CH) ? cfg_in[c].ext_src : 1'b0;
			assign tick = use_ext ? (active && ext_event[c])
				: pre_tick;

			// Count of one or zero ends the pass on this tick
			assign at_end = (count_q <= `RDCT_CNT_W'(1));
			assign terminal = tick && at_end;

			// Divider that counts only while active, restarted by a start pulse
			always_ff @(posedge mclk_in) begin
				if (!nrst_in) begin
					pre_q <= `RDCT_RST_PRE;
				end else if (start_in[c]) begin
					pre_q <= `RDCT_RST_PRE;
				end else if (active) begin
					pre_q <= pre_q + `RDCT_PRE_W'(1);
				end
			end

			// Channel run state
			always_ff @(posedge mclk_in) begin
				if (!nrst_in) begin
					state_q <= RDCT_IDLE;
				end else if (start_in[c]) begin
					state_q <= RDCT_RUN;
				end else begin
					case (state_q)
						RDCT_IDLE: state_q <= RDCT_IDLE;
						RDCT_RUN: begin
							if (terminal && !cfg_in[c].continuous) begin
								state_q <= RDCT_DONE;
							end
						end
						RDCT_DONE: state_q <= RDCT_DONE;
						default: state_q <= RDCT_IDLE;
					endcase
				end
			end

			// Down counter; reloads at the terminal count when continuous, else clears to zero
			always_ff @(posedge mclk_in) begin
				if (!nrst_in) begin
					count_q <= `RDCT_RST_COUNT;
				end else if (start_in[c]) begin
					count_q <= cfg_in[c].reload;
				end else if (terminal) begin
					if (cfg_in[c].continuous) begin
						count_q <= cfg_in[c].reload;
					end else begin
						count_q <= `RDCT_RST_COUNT;
					end
				end else if (tick) begin
					count_q <= count_q - `RDCT_CNT_W'(1);
				end
			end

			// Sticky terminal flag; a set in the clear cycle wins
			always_ff @(posedge mclk_in) begin
				if (!nrst_in) begin
					tc_flag_q <= 1'b0;
				end else if (terminal) begin
					tc_flag_q <= 1'b1;
				end else if (clear_in[c]) begin
					tc_flag_q <= 1'b0;
				end
			end

			// One-cycle marker and toggling timer output
			always_ff @(posedge mclk_in) begin
				if (!nrst_in) begin
					tc_pulse_q <= 1'b0;
					tout_q <= 1'b0;
				end else begin
					tc_pulse_q <= terminal;
					if (start_in[c]) begin
						tout_q <= 1'b0;
					end else if (terminal) begin
						tout_q <= ~tout_q;
					end
				end
			end

			assign stat_out[c].count = count_q;
			assign stat_out[c].running = (state_q == RDCT_RUN);
			assign stat_out[c].tc_flag = tc_flag_q;
			assign stat_out[c].tc_pulse = tc_pulse_q;
			assign stat_out[c].tout = tout_q;
		end
	endgenerate

	// Output pins belong to the top channels of the bank
	genvar p;
	generate
		for (p = 0; p < OUT_CH; p++) begin : g_out
			localparam int CH = NUM_CH - OUT_CH + p;
			logic pin_q;
			logic oe_n_q;

			// Registered so the pin does not glitch on config writes
			always_ff @(posedge mclk_in) begin
				if (!nrst_in) begin
					pin_q <= 1'b0;
					oe_n_q <= 1'b1;
				end else begin
					pin_q <= stat_out[CH].tout;
					oe_n_q <= ~cfg_in[CH].out_sel;
				end
			end

			assign tout_pin_out[p] = pin_q;
			assign tout_pin_oe_n_out[p] = oe_n_q;
		end
	endgenerate

endmodule

// File: shared/rdct_params.svh
// Constants for the reloadable count timer bank
`ifndef RDCT_PARAMS_SVH
`define RDCT_PARAMS_SVH

`define RDCT_NUM_CH 6
`define RDCT_EXT_CH 4
`define RDCT_OUT_CH 2
`define RDCT_CNT_W 16
`define RDCT_PRE_W 8

// Prescaler tap codes and the low-bit masks that mark each tick
`define RDCT_TAP_DIV4 2'h0
`define RDCT_TAP_DIV16 2'h1
`define RDCT_TAP_DIV64 2'h2
`define RDCT_TAP_DIV256 2'h3
`define RDCT_MASK_DIV4 8'h03
`define RDCT_MASK_DIV16 8'h0F
`define RDCT_MASK_DIV64 8'h3F
`define RDCT_MASK_DIV256 8'hFF

// Reset values
`define RDCT_RST_COUNT 16'h0000
`define RDCT_RST_PRE 8'h00

`endif

// File: shared/rdct_pkg.sv
// Types shared by the reloadable count timer bank
`include "rdct_params.svh"

package rdct_pkg;

	typedef enum logic [1:0] {
		RDCT_IDLE = 2'b00,
		RDCT_RUN = 2'b01,
		RDCT_DONE = 2'b11
	} rdct_state_e;

	// Per-channel configuration, held steady by the owner
	typedef struct packed {
		logic [`RDCT_CNT_W-1:0] reload;
		logic [1:0] tap;
		logic continuous;
		logic ext_src;
		logic enable;
		logic out_sel;
	} rdct_cfg_s;

	// Per-channel status from flip-flops; running is decoded from state_q
	typedef struct packed {
		logic [`RDCT_CNT_W-1:0] count;
		logic running;
		logic tc_flag;
		logic tc_pulse;
		logic tout;
	} rdct_stat_s;

endpackage

// File: testbench/rdct_props.sv
// Port-level temporal checks for the timer bank
module rdct_props
	import rdct_pkg::*;
#(
	parameter int NUM_CH = 6,
	parameter int EXT_CH = 4,
	parameter int OUT_CH = 2,
	parameter int COUNT_W = 16
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire rdct_pkg::rdct_cfg_s [NUM_CH-1:0] cfg_in,
	input wire logic [NUM_CH-1:0] start_in,
	input wire logic [NUM_CH-1:0] clear_in,
	input wire logic [EXT_CH-1:0] ev_pin_in,
	input wire rdct_pkg::rdct_stat_s [NUM_CH-1:0] stat_out,
	input wire logic [OUT_CH-1:0] tout_pin_out,
	input wire logic [OUT_CH-1:0] tout_pin_oe_n_out
);
	rdct_cfg_s c0;
	rdct_stat_s s0;
	assign c0 = cfg_in[0];
	assign s0 = stat_out[0];
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);
	sequence go4_s;
		start_in[0] && c0.tap == 2'h0 && c0.enable && !c0.ext_src
			&& c0.reload > 16'h0001;
	endsequence
	sequence hold4_s;
		(!start_in[0] && s0.count == c0.reload)[*4];
	endsequence
	load_a: assert property (start_in[0] |=> s0.running
		&& s0.count == $past(c0.reload)) else $error("no load");
	div_four_a: assert property (go4_s |=> hold4_s
		##1 s0.count == c0.reload - 16'h0001) else $error("bad /4");
	dec_one_a: assert property (s0.running && s0.count > 16'h0001
		&& !start_in[0] |=> s0.count == $past(s0.count)
		|| s0.count == $past(s0.count) - 16'h0001) else $error("bad step");
	stop_single_a: assert property ($fell(s0.running) |->
		s0.count == 16'h0000 && s0.tc_flag && s0.tc_pulse)
		else $error("bad stop");
	pulse_once_a: assert property (stat_out[4].tc_pulse |=>
		!stat_out[4].tc_pulse) else $error("long pulse");
	cont_reload_a: assert property (stat_out[1].tc_pulse |->
		stat_out[1].count == (cfg_in[1].continuous ? cfg_in[1].reload
		: 16'h0000) && stat_out[1].running == cfg_in[1].continuous)
		else $error("bad reload");
	pin_follow_a: assert property (1'b1 |=> tout_pin_out ==
		{$past(stat_out[5].tout), $past(stat_out[4].tout)}
		&& tout_pin_oe_n_out == ~{$past(cfg_in[5].out_sel),
		$past(cfg_in[4].out_sel)}) else $error("bad pins");
	freeze_a: assert property (!cfg_in[2].enable && !start_in[2]
		|=> $stable(stat_out[2].count)) else $error("not frozen");
endmodule

bind rdct_top rdct_props #(.NUM_CH(NUM_CH), .EXT_CH(EXT_CH),
	.OUT_CH(OUT_CH), .COUNT_W(COUNT_W)) i_props (.mclk_in(mclk_in),
	.nrst_in(nrst_in), .cfg_in(cfg_in), .start_in(start_in),
	.clear_in(clear_in), .ev_pin_in(ev_pin_in), .stat_out(stat_out),
	.tout_pin_out(tout_pin_out), .tout_pin_oe_n_out(tout_pin_oe_n_out));

// File: testbench/testbench.sv
// Self-checking bench for the timer bank
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import rdct_pkg::*;
	logic mclk_in = 0;
	logic nrst_in = 0;
	rdct_cfg_s [5:0] cfg = '0;
	logic [5:0] start = '0;
	logic [5:0] clr = '0;
	logic [3:0] ev = '0;
	rdct_stat_s [5:0] st;
	logic [1:0] pin;
	logic [1:0] oe_n;
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	// Channel, tap, reload, continuous
	int rows [6][4] = '{'{0, 0, 2, 0}, '{1, 1, 3, 1}, '{2, 2, 1, 0},
		'{3, 3, 2, 1}, '{4, 0, 1, 1}, '{5, 1, 2, 0}};
	rdct_top i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .cfg_in(cfg),
		.start_in(start), .clear_in(clr), .ev_pin_in(ev), .stat_out(st),
		.tout_pin_out(pin), .tout_pin_oe_n_out(oe_n));
	initial forever #50 mclk_in = ~mclk_in;
	task automatic step(int n);
		repeat (n) @(posedge mclk_in);
		#10;
	endtask
	task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Longest path is about 730 cycles
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		int c, n, r;
		step(3);
		chk("oe_n rst", 16'(oe_n), 16'h0003);
		chk("run rst", 16'(st[0].running), 16'h0000);
		nrst_in = 1;
		foreach (rows[i]) begin
			c = rows[i][0];
			n = 4 << (2 * rows[i][1]);
			r = rows[i][2];
			cfg[c].reload = 16'(r);
			cfg[c].tap = 2'(rows[i][1]);
			cfg[c].continuous = rows[i][3] != 0;
			cfg[c].enable = 1'b1;
			start[c] = 1'b1;
			step(1);
			start[c] = 1'b0;
			chk("loaded", st[c].count, 16'(r));
			step(n * r);
			chk("end", st[c].count, rows[i][3] ? 16'(r) : 16'h0);
			chk("pulse", 16'(st[c].tc_pulse), 16'h0001);
			chk("run", 16'(st[c].running), 16'(rows[i][3]));
		end
		cfg[4].out_sel = 1'b1;
		step(2);
		chk("oe_n", 16'(oe_n), 16'h0002);
		// Restart clears tout; pin trails it by one cycle
		start[4] = 1'b1;
		step(1);
		start[4] = 1'b0;
		step(1);
		chk("pin low", 16'(pin[0]), 16'h0000);
		step(4);
		chk("pin high", 16'(pin[0]), 16'h0001);
		chk("tout", 16'(st[4].tout), 16'h0001);
		// Clear meets the next terminal: set must win
		clr[4] = 1'b1;
		step(2);
		chk("clr4", 16'(st[4].tc_flag), 16'h0000);
		step(1);
		chk("set wins", 16'(st[4].tc_flag), 16'h0001);
		chk("pulse4", 16'(st[4].tc_pulse), 16'h0001);
		clr[4] = 1'b0;
		step(1);
		chk("pulse4 off", 16'(st[4].tc_pulse), 16'h0000);
		chk("flag4 kept", 16'(st[4].tc_flag), 16'h0001);
		// Disabled channel holds its count until enabled
		cfg[2].enable = 1'b0;
		cfg[2].tap = 2'h0;
		cfg[2].reload = 16'h0005;
		cfg[2].continuous = 1'b1;
		start[2] = 1'b1;
		step(1);
		start[2] = 1'b0;
		step(8);
		chk("frozen", st[2].count, 16'h0005);
		chk("frozen run", 16'(st[2].running), 16'h0001);
		cfg[2].enable = 1'b1;
		step(4);
		chk("thawed", st[2].count, 16'h0004);
		clr[0] = 1'b1;
		step(1);
		clr[0] = 1'b0;
		chk("flag clr", 16'(st[0].tc_flag), 16'h0000);
		// Events only: prescaler must not move the count
		cfg[0].ext_src = 1'b1;
		cfg[0].reload = 16'h0003;
		start[0] = 1'b1;
		step(1);
		start[0] = 1'b0;
		step(8);
		chk("ext idle", st[0].count, 16'h0003);
		repeat (3) begin
			ev[0] = 1'b1;
			step(3);
			ev[0] = 1'b0;
			step(3);
		end
		chk("ext end", st[0].count, 16'h0000);
		chk("ext flag", 16'(st[0].tc_flag), 16'h0001);
		chk("ch1 on", 16'(st[1].running), 16'h0001);
		nrst_in = 0;
		step(3);
		chk("cnt rst", st[1].count, 16'h0000);
		chk("oe_n rst2", 16'(oe_n), 16'h0003);
		conclude();
	end
endmodule
